// *** core/fsync_params.svh ***
// Constants for the switching frequency, sync and strap decode block.
// Included by the package and the block; holds definitions only.
`ifndef FSYNC_PARAMS_SVH
`define FSYNC_PARAMS_SVH
`define CLK_PERIOD_NS 8
`define CLK_KHZ 125000
`define WIN_US 100
`define WIN_CYC (`WIN_US * 1000 / `CLK_PERIOD_NS)
`define LOST_NS 5000
`define LOST_CYC ((`LOST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KHZ_PER_EDGE (1000 / `WIN_US)
`define FREQ_MIN_KHZ 11'h12c
`define FREQ_MAX_KHZ 11'h3e8
`define FREQ_OPEN_KHZ 11'h23f
`define FREQ_STEP_KHZ 11'h032
`define STRAP_TOP_BIN 5'h0f
`define ADDR_BASE 10'h00a
`define ADDR_MAX 7'h7f
`define ADDR_COL_STEP 10'h018
`define RS_GROUP 5'h05
`define DEG_FULL 19'h00168
`define OFS_CTRL 4'h0
`define OFS_FREQ 4'h4
`define OFS_ILV 4'h8
`define OFS_STAT 4'hc
`define RST_CTRL_EN 1'b0
`endif

// *** core/fsync_pkg.sv ***
// Types shared by the switching frequency block.
// Assumes fsync_params.svh sits beside it.
`include "fsync_params.svh"
package fsync_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_IDLE = 3'b010,
        ST_RUN = 3'b100
    } fsm_state_t;
    typedef logic [10:0] freq_khz_t;
endpackage

// *** core/fsync.sv ***
// Switching frequency select, external sync lock, interleave phase and
// address strap decode, with a classic Wishbone register slave.
// Assumes strap bins come from an outside resistor measurement and the
// sync pin clock arrives on its own clock port.
`timescale 1ns/100ps
`include "fsync_params.svh"
module fsync #(
    parameter int WIN_CYC = `WIN_CYC
) (
    input wire logic ref_clk_i, // 125 MHz core clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic sync_clk_i, // External sync pin clock
    input wire logic en_pin_i, // Hardware enable pin
    input wire logic [4:0] sync_strap_bin_i, // Sync strap bin 0..16
    input wire logic [4:0] address_strap_pin_a_bin_i, // Row bin 0..23
    input wire logic [4:0] address_strap_pin_b_bin_i, // Column bin 0..24
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic cycle_start_o, // Switching cycle start pulse
    output logic pwm_centre_o, // PWM pulse centre marker
    output logic sync_locked_o, // Aligned to external clock
    output logic output_enabled_o, // Output running
    output logic [10:0] freq_khz_o, // Held switching frequency
    output logic [8:0] phase_deg_o, // Interleave phase in degrees
    output logic [6:0] smbus_addr_o, // Decoded 7-bit address
    output logic [2:0] inductor_sense_resistance_o // Units of 0.4 milliohm
);
    localparam int LOST_CYC = `LOST_CYC;

    fsync_pkg::fsm_state_t state_q;
    fsync_pkg::freq_khz_t freq_q;
    fsync_pkg::freq_khz_t meas_q;
    logic tog_q;
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic en_s1_q, en_s2_q;
    logic [14:0] strap_s1_q, strap_s2_q;
    logic [4:0] sbin_q, row_q, col_q;
    logic [13:0] win_q;
    logic [7:0] edges_q;
    logic [9:0] since_q;
    logic present_q, locked_q;
    logic ctrl_en_q;
    logic [2:0] ilv_q;
    logic [9:0] period_q, cnt_q, cnt_d, centre_q;
    logic start_q, centre_hit_q;
    logic [6:0] addr_q;
    logic [2:0] rs_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic sync_edge, win_done, enable, running;
    logic por_load, en_load, bus_rd, bus_wr;
    logic [9:0] addr_sum;
    logic [6:0] addr_now;
    fsync_pkg::freq_khz_t wr_freq, strap_khz;

    function automatic fsync_pkg::freq_khz_t clamp_khz(input logic [11:0] f);
        if (f < 12'(`FREQ_MIN_KHZ)) begin
            return `FREQ_MIN_KHZ;
        end
        if (f > 12'(`FREQ_MAX_KHZ)) begin
            return `FREQ_MAX_KHZ;
        end
        return f[10:0];
    endfunction

    function automatic logic [8:0] phase_deg(input logic [2:0] code);
        case (code)
            3'h0: return 9'h000;
            3'h1: return 9'h03c;
            3'h2: return 9'h078;
            3'h3: return 9'h0b4;
            3'h4: return 9'h0f0;
            3'h5: return 9'h12c;
            3'h6: return 9'h05a;
            default: return 9'h10e;
        endcase
    endfunction

    // Sync pin domain: one toggle per rising edge
    always_ff @(posedge sync_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
        end
    end

    // Toggle crossing; edge seen between second and third stage
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end
    assign sync_edge = tog_s2_q ^ tog_s3_q;

    // Pin synchronisers for enable and strap bins
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            strap_s1_q <= 15'h0000;
            strap_s2_q <= 15'h0000;
        end else begin
            en_s1_q <= en_pin_i;
            en_s2_q <= en_s1_q;
            strap_s1_q <= {sync_strap_bin_i, address_strap_pin_a_bin_i,
                address_strap_pin_b_bin_i};
            strap_s2_q <= strap_s1_q;
        end
    end

    // Edge count per window, loss by timeout
    assign win_done = (win_q == 14'(WIN_CYC - 1));
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            win_q <= 14'h0000;
            edges_q <= 8'h00;
            meas_q <= `FREQ_MIN_KHZ;
        end else if (win_done) begin
            win_q <= 14'h0000;
            edges_q <= 8'h00;
            meas_q <= clamp_khz(12'(edges_q) * 12'(`KHZ_PER_EDGE));
        end else begin
            win_q <= win_q + 14'h0001;
            edges_q <= edges_q + {7'h00, sync_edge};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_q <= 10'h000;
            present_q <= 1'b0;
        end else if (sync_edge) begin
            since_q <= 10'h000;
            present_q <= 1'b1;
        end else if (since_q == 10'(LOST_CYC - 1)) begin
            present_q <= 1'b0;
        end else begin
            since_q <= since_q + 10'h001;
        end
    end

    // Strap decode: frequency, address and sense resistance
    always_comb begin
        if (sbin_q == 5'h00 || sbin_q > `STRAP_TOP_BIN) begin
            strap_khz = `FREQ_OPEN_KHZ;
        end else begin
            strap_khz = `FREQ_MIN_KHZ
                + 11'(`FREQ_STEP_KHZ * (11'(sbin_q) - 11'h001));
        end
    end
    assign addr_sum = `ADDR_BASE + 10'(row_q) + 10'(`ADDR_COL_STEP * 10'(col_q));
    assign addr_now = (addr_sum > 10'(`ADDR_MAX)) ? `ADDR_MAX : addr_sum[6:0];

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sbin_q <= 5'h00;
            row_q <= 5'h00;
            col_q <= 5'h00;
            addr_q <= 7'h00;
            rs_q <= 3'h1;
        end else begin
            if (state_q == fsync_pkg::ST_POR) begin
                {sbin_q, row_q, col_q} <= strap_s2_q;
            end
            addr_q <= addr_now;
            rs_q <= 3'(col_q / `RS_GROUP) + 3'h1;
        end
    end

    // Power-on and enable sequencing
    assign enable = en_s2_q | ctrl_en_q;
    assign running = (state_q == fsync_pkg::ST_RUN);
    assign por_load = (state_q == fsync_pkg::ST_POR) && win_done;
    assign en_load = (state_q == fsync_pkg::ST_IDLE) && enable;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= fsync_pkg::ST_POR;
        end else begin
            case (state_q)
                fsync_pkg::ST_POR: begin
                    if (win_done) begin
                        state_q <= fsync_pkg::ST_IDLE;
                    end
                end
                fsync_pkg::ST_IDLE: begin
                    if (enable) begin
                        state_q <= fsync_pkg::ST_RUN;
                    end
                end
                fsync_pkg::ST_RUN: begin
                    if (!enable) begin
                        state_q <= fsync_pkg::ST_IDLE;
                    end
                end
                default: state_q <= fsync_pkg::ST_POR;
            endcase
        end
    end

    // Frequency value: sequencing loads win over bus writes
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freq_q <= `FREQ_OPEN_KHZ;
        end else if (por_load) begin
            freq_q <= present_q ? `FREQ_MIN_KHZ : strap_khz;
        end else if (en_load) begin
            if (present_q) begin
                freq_q <= meas_q;
            end
        end else if (bus_wr && wb_adr_i == {4'h0, `OFS_FREQ}) begin
            if (wr_freq >= `FREQ_MIN_KHZ && wr_freq <= `FREQ_MAX_KHZ) begin
                freq_q <= wr_freq;
            end
        end
    end

    // Wishbone slave, one wait state per access
    assign bus_rd = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign wr_freq = {wb_sel_i[1] ? wb_dat_i[10:8] : freq_q[10:8],
        wb_sel_i[0] ? wb_dat_i[7:0] : freq_q[7:0]};

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_rd;
            if (bus_rd) begin
                dat_q <= 32'h00000000;
                if (wb_adr_i[7:4] == 4'h0) begin
                    case (wb_adr_i[3:0])
                        `OFS_CTRL: dat_q <= {31'h00000000, ctrl_en_q};
                        `OFS_FREQ: dat_q <= {21'h000000, freq_q};
                        `OFS_ILV: dat_q <= {29'h00000000, ilv_q};
                        `OFS_STAT: dat_q <= {6'h00, state_q, present_q, locked_q,
                            rs_q, meas_q, addr_q};
                        default: dat_q <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_en_q <= `RST_CTRL_EN;
        end else if (bus_wr && wb_adr_i == {4'h0, `OFS_CTRL} && wb_sel_i[0]) begin
            ctrl_en_q <= wb_dat_i[0];
        end
    end

    // Interleave code: strap default, bus write only while disabled
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ilv_q <= 3'h0;
        end else if (por_load) begin
            ilv_q <= addr_now[2:0];
        end else if (bus_wr && wb_adr_i == {4'h0, `OFS_ILV} && wb_sel_i[0] && !running) begin
            ilv_q <= wb_dat_i[2:0];
        end
    end

    // Switching cycle counter
    always_comb begin
        cnt_d = cnt_q;
        if (!running) begin
            cnt_d = 10'h000;
        end else if (sync_edge && present_q) begin
            cnt_d = 10'h000;
        end else if (cnt_q >= period_q - 10'h001) begin
            cnt_d = 10'h000;
        end else begin
            cnt_d = cnt_q + 10'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            period_q <= 10'h0d9;
            centre_q <= 10'h000;
            cnt_q <= 10'h000;
            start_q <= 1'b0;
            centre_hit_q <= 1'b0;
        end else begin
            period_q <= 10'(17'(`CLK_KHZ) / 17'(freq_q));
            centre_q <= 10'(19'(period_q) * 19'(phase_deg(ilv_q)) / `DEG_FULL);
            cnt_q <= cnt_d;
            start_q <= running && cnt_d == 10'h000;
            centre_hit_q <= running && cnt_d == centre_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            locked_q <= 1'b0;
        end else if (!running || !present_q) begin
            locked_q <= 1'b0;
        end else if (sync_edge) begin
            locked_q <= 1'b1;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign cycle_start_o = start_q;
    assign pwm_centre_o = centre_hit_q;
    assign sync_locked_o = locked_q;
    assign output_enabled_o = running;
    assign freq_khz_o = freq_q;
    assign phase_deg_o = phase_deg(ilv_q);
    assign smbus_addr_o = addr_q;
    assign inductor_sense_resistance_o = rs_q;

    freq_range_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        freq_q >= `FREQ_MIN_KHZ && freq_q <= `FREQ_MAX_KHZ)
        else $error("frequency out of range");
    sync_align_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        running && enable && sync_edge && present_q |=> cnt_q == 10'h000 && start_q)
        else $error("cycle not aligned to sync edge");
    free_run_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        running && enable && !present_q && cnt_q == period_q - 10'h001 |=> cnt_q == 10'h000)
        else $error("free run period wrong");
    por_clock_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        por_load && present_q |=> freq_q == `FREQ_MIN_KHZ)
        else $error("power-on clock did not load minimum");
    por_strap_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        por_load && !present_q |=> freq_q == $past(strap_khz))
        else $error("strap frequency not loaded");
    enable_meas_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        en_load && present_q |=> freq_q == $past(meas_q) && running)
        else $error("measured frequency not loaded at enable");
    enable_keep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        en_load && !present_q |=> $stable(freq_q))
        else $error("frequency changed without clock");
    ilv_lock_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        running |=> $stable(ilv_q))
        else $error("interleave changed while running");
    addr_sat_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        col_q == 5'h18 && $stable(col_q) |=> addr_q == `ADDR_MAX)
        else $error("address not saturated");
endmodule

// *** sim/sync_src.sv ***
// External sync clock source at the far side of the sync pin.
// Assumes the bench starts and stops it through run_i.
`timescale 1ns/100ps
module sync_src #(
    parameter int HALF_NS = 1000
) (
    input wire logic run_i, // Clock runs while high
    output logic sync_o // Sync pin clock
);
    // Fixed rate inside 300 kHz..1 MHz, never retuned while running
    // Bench raises run_i before enabling the output in its clocked cases; the first case enables with run_i low
    // Stopped clock rests low; odd offset keeps rising edges off the core clock edges
    initial begin
        sync_o = 1'b0;
        forever begin
            wait (run_i);
            #(HALF_NS + 3) sync_o = 1'b1;
            #(HALF_NS - 3) sync_o = 1'b0;
        end
    end
endmodule

// *** sim/tb_fsync.sv ***
// Self-checking bench for the switching frequency and strap decode block.
// Assumes the sync source model and the core package and header.
`timescale 1ns/100ps
`include "fsync_params.svh"
module tb_fsync;
    logic ref_clk_i, nrst_i, sync_clk_i, en_pin_i, sync_run;
    logic cyc, stb, we, ack, cyc_st, centre, locked, oen;
    logic [4:0] sb, ra, cb;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [10:0] freq;
    logic [8:0] ph;
    logic [6:0] addr;
    logic [2:0] rs;
    logic [8:0] ph_tab [8] = '{9'h000, 9'h03c, 9'h078, 9'h0b4, 9'h0f0, 9'h12c, 9'h05a, 9'h10e};
    int n_errors = 0;
    int compares = 0;
    int p;

    fsync u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sync_clk_i(sync_clk_i),
        .en_pin_i(en_pin_i), .sync_strap_bin_i(sb), .address_strap_pin_a_bin_i(ra),
        .address_strap_pin_b_bin_i(cb), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cycle_start_o(cyc_st), .pwm_centre_o(centre), .sync_locked_o(locked),
        .output_enabled_o(oen), .freq_khz_o(freq), .phase_deg_o(ph), .smbus_addr_o(addr),
        .inductor_sense_resistance_o(rs));
    sync_src #(.HALF_NS(1000)) u_src (.run_i(sync_run), .sync_o(sync_clk_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task end_of_test;
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Classic single cycle: hold until ack, release after it
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) chk("ack", 32'h0, 32'h1);
    endtask

    task rst(input logic [4:0] s, input logic [4:0] a, input logic [4:0] b);
        nrst_i <= 1'b0;
        en_pin_i <= 1'b0;
        sb <= s;
        ra <= a;
        cb <= b;
        repeat (4) @(posedge ref_clk_i);
        chk("reset freq", 32'(freq), 32'h23f);
        nrst_i <= 1'b1;
        repeat (`WIN_CYC + 20) @(posedge ref_clk_i);
    endtask

    // Cycles between two switching cycle starts
    task period(output int t);
        int n;
        n = 0;
        t = 1;
        while (cyc_st !== 1'b1 && n < 2000) begin
            @(posedge ref_clk_i);
            n++;
        end
        @(posedge ref_clk_i);
        while (cyc_st !== 1'b1 && t < 2000) begin
            @(posedge ref_clk_i);
            t++;
        end
    endtask

    function automatic logic [31:0] near(input int v, input int lo, input int hi);
        return 32'(v >= lo && v <= hi);
    endfunction

    initial begin
        #700000;
        n_errors++;
        end_of_test();
    end

    initial begin
        nrst_i = 1'b0;
        en_pin_i = 1'b0;
        sync_run = 1'b0;
        {cyc, stb, we} = 3'h0;
        {sb, ra, cb} = 15'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        // No sync clock at power-on: strap decode
        rst(5'h03, 5'h05, 5'h02);
        chk("strap freq", 32'(freq), 32'h190);
        chk("addr", 32'(addr), 32'h3f);
        chk("rs", 32'(rs), 32'h1);
        chk("phase", 32'(ph), 32'h10e);
        wb(1'b1, `OFS_FREQ, 32'h2bc);
        wb(1'b0, `OFS_FREQ, 32'h0);
        chk("freq rd", q, 32'h2bc);
        wb(1'b1, `OFS_FREQ, 32'h4b0);
        wb(1'b1, `OFS_FREQ, 32'h12b);
        wb(1'b0, `OFS_FREQ, 32'h0);
        chk("freq range", q, 32'h2bc);
        wb(1'b1, `OFS_FREQ, 32'h3e8);
        repeat (2) @(posedge ref_clk_i);
        chk("freq max", 32'(freq), 32'h3e8);
        wb(1'b0, 8'h01, 32'h0);
        chk("unmapped rd", q, 32'h0);
        wb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl rd", q, 32'h0);
        wb(1'b1, 4'h0 , 32'h0);
        // Upper address bits set: frequency alias must be ignored
        wb(1'b1, 8'h14, 32'h258);
        wb(1'b0, `OFS_FREQ, 32'h0);
        chk("unmapped wr", q, 32'h3e8);
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped hi", q, 32'h0);
        wb(1'b0, `OFS_STAT, 32'h0);
        chk("status", q & 32'h03fc007f, 32'h0104003f);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, `OFS_ILV, 32'(i));
            repeat (2) @(posedge ref_clk_i);
            chk("ilv phase", 32'(ph), 32'(ph_tab[i]));
        end
        wb(1'b1, `OFS_CTRL, 32'h1);
        repeat (4) @(posedge ref_clk_i);
        chk("enabled", 32'(oen), 32'h1);
        chk("freq kept", 32'(freq), 32'h3e8);
        wb(1'b1, `OFS_ILV, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        chk("ilv locked", 32'(ph), 32'h10e);
        period(p);
        chk("free period", 32'(p), 32'h7d);
        // Clock present at power-on and at enable
        sync_run <= 1'b1;
        rst(5'h00, 5'h17, 5'h18);
        chk("por freq", 32'(freq), 32'h12c);
        chk("addr sat", 32'(addr), 32'h7f);
        chk("rs top", 32'(rs), 32'h5);
        en_pin_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        chk("meas freq", near(int'(freq), 490, 510), 32'h1);
        repeat (2500) @(posedge ref_clk_i);
        chk("locked", 32'(locked), 32'h1);
        period(p);
        chk("sync period", near(p, 249, 251), 32'h1);
        // Centre marker at 270 degrees of a 250 cycle period
        while (cyc_st !== 1'b1) @(posedge ref_clk_i);
        p = 0;
        while (centre !== 1'b1 && p < 2000) begin
            @(posedge ref_clk_i);
            p++;
        end
        chk("centre delay", 32'(p), 32'hbb);
        sync_run <= 1'b0;
        repeat (800) @(posedge ref_clk_i);
        chk("lost", 32'(locked), 32'h0);
        chk("lost freq", near(int'(freq), 490, 510), 32'h1);
        period(p);
        chk("lost period", near(p, 245, 256), 32'h1);
        // Clock arrives after power-on, before enable
        rst(5'h10, 5'h00, 5'h00);
        chk("open freq", 32'(freq), 32'h23f);
        chk("addr base", 32'(addr), 32'h0a);
        sync_run <= 1'b1;
        repeat (2 * `WIN_CYC) @(posedge ref_clk_i);
        wb(1'b1, `OFS_CTRL, 32'h1);
        repeat (4) @(posedge ref_clk_i);
        chk("late freq", near(int'(freq), 490, 510), 32'h1);
        end_of_test();
    end
endmodule
